// ---- shared/eimon_params.svh ----
// engine interface monitor: register offsets, fields, resets and timing
`ifndef EIMON_PARAMS_SVH
`define EIMON_PARAMS_SVH
`define EIMON_CLK_HZ        40000000
`define EIMON_STOP_S        10
`define EIMON_CHK_DLY_S     3
`define EIMON_CHK_LEN_S     2
`define EIMON_MAINT_FIRST_H 50
`define EIMON_MAINT_NEXT_H  125
`define EIMON_SEC_PER_H     3600
`define EIMON_ALT_PPR_X100  1029
// register byte offsets
`define EIMON_REG_CFG       5'h00
`define EIMON_REG_STATUS    5'h04
`define EIMON_REG_ALARM     5'h08
`define EIMON_REG_RPM       5'h0C
`define EIMON_REG_MAINT     5'h10
`define EIMON_REG_CAL       5'h14
`define EIMON_REG_CTRL      5'h18
`define EIMON_REG_SENS      5'h1C
// cfg fields
`define EIMON_CFG_ENG_LSB   0
`define EIMON_CFG_POS_LSB   3
`define EIMON_CFG_SEND_BIT  5
`define EIMON_CFG_TRIM_BIT  6
`define EIMON_CFG_TACH_BIT  7
`define EIMON_CFG_S1_LSB    8
`define EIMON_CFG_S2_LSB    16
`define EIMON_CFG_LOC_BIT   24
`define EIMON_CFG_DUAL_BIT  25
// reset config: alternate trim type selected
`define EIMON_CFG_RESET     32'h0000_0040
`define EIMON_CAL_RESET     16'h0405
// alarm bit positions
`define EIMON_AL_OIL        0
`define EIMON_AL_CLVL       1
`define EIMON_AL_CTMP       2
`define EIMON_AL_WIF        3
`define EIMON_AL_CHG        4
`define EIMON_AL_VOLT       5
`define EIMON_AL_MAINT      6
`define EIMON_AL_SEC        7
`define EIMON_AL_CHECK      8
`define EIMON_AL_WARN1      9
`endif

// ---- shared/eimon_pkg.sv ----
// engine interface monitor types
`default_nettype none
package eimon_pkg;
	typedef enum logic [1:0] {
		EIMON_OFF,
		EIMON_RUN,
		EIMON_STOP
	} eimon_pwr_t;
endpackage : eimon_pkg
`default_nettype wire

// ---- verilog/eimon_top.sv ----
// engine interface monitor: power, alarms, tach, maintenance, wishbone regs
// Notes on behaviour
// - key on: power up, network power on, sample and broadcast data
// - key off: network power off, engine stop held 10 s
// - after stop interval, module enters low power until next key on
// - check-engine alarm starts 3 s after key on, lasts 2 s
// - pass engine alarms; generate voltage, maintenance, security alarms
// - engine stopped: only coolant level, voltage, over-temp, water-in-fuel; check, security and warning alarms still shown
// - maintenance alarm at 50 running hours, then every 125 hours
// - maintenance timer runs only while configuring display is present
// - security active with start command asserts engine stop
// - security input is active low
// - cranking not blocked; security reported as its own alarm
// - security also raised in generic first-level warning
// - engine speed from pickup pulses, ppr 117/129/127/116/97
// - alternator source 10.29 ppr, calibratable from display
// - trim sensor standard or alternate; alternate by default
// - hold display-written configuration incl. engine position
// - sensor 1: fuel, water or waste, descriptor, US/euro scale
// - sensor 2 rudder: 10..180 ohm maps to -40..+40 degrees
// - measured data and alarms broadcast periodically
// - dual helm: start inhibited without second helm connected
// - maintenance reset clears elapsed count regardless of hours
`include "eimon_params.svh"
`default_nettype none
module eimon_top
	import eimon_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = `EIMON_CLK_HZ, // time base tick
	parameter int unsigned BCAST_SEC  = 1              // broadcast period
) (
	input  wire logic        core_clk_i,   // 40 MHz
	input  wire logic        rst_n_i,      // async reset, active low
	input  wire logic        key_on_i,     // ignition key pin
	input  wire logic        start_cmd_i,  // starter request pin
	input  wire logic        security_n_i, // security switch, low active
	input  wire logic        helm2_ok_i,   // second helm harness present
	input  wire logic        tach_pulse_i, // pickup or alternator pulses
	input  wire logic [4:0]  eng_alarm_i,  // oil,clvl,ctmp,wif,chg pins
	input  wire logic        low_volt_i,   // battery below threshold
	input  wire logic        display_i,    // configuring display seen
	input  wire logic [7:0]  sens2_ohm_i,  // sensor 2 sender ohms
	input  wire logic [31:0] wb_adr_i,     // wishbone address
	input  wire logic [31:0] wb_dat_i,     // wishbone write data
	input  wire logic [3:0]  wb_sel_i,     // byte enables
	input  wire logic        wb_we_i,      // write
	input  wire logic        wb_cyc_i,     // cycle
	input  wire logic        wb_stb_i,     // strobe
	output logic      [31:0] wb_dat_o,     // read data
	output logic             wb_ack_o,     // ack
	output logic             wb_err_o,     // unmapped address
	output logic             mod_pwr_o,    // module powered
	output logic             net_pwr_o,    // network supply
	output logic             eng_stop_o,   // engine stop / fuel cut
	output logic             start_en_o,   // starter permitted
	output logic             buzzer_o,     // audible alarm
	output logic             bcast_o,      // broadcast strobe, one cycle
	output logic      [9:0]  alarm_o       // reported alarm word
);
	localparam int unsigned STOP_S = `EIMON_STOP_S;
	localparam int unsigned CHK_LO = `EIMON_CHK_DLY_S;
	localparam int unsigned CHK_HI = `EIMON_CHK_DLY_S + `EIMON_CHK_LEN_S;
	localparam int unsigned M_FIRST = `EIMON_MAINT_FIRST_H;
	localparam int unsigned M_NEXT = `EIMON_MAINT_NEXT_H;
	initial begin
		if (SEC_CYCLES < 2 || BCAST_SEC < 1 || BCAST_SEC > 256)
			$error("eimon_top: bad time base parameters");
	end

	logic rst_s1_q, rst_n;
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// three-stage pin synchronisers; change accepted when stage 2 == 3
	localparam int NPIN = 11;
	logic [NPIN-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q;
	assign pin_raw = {display_i, low_volt_i, eng_alarm_i, tach_pulse_i,
		helm2_ok_i, start_cmd_i, key_on_i};
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			always_ff @(posedge core_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					s1_q[gi]  <= 1'b0;
					s2_q[gi]  <= 1'b0;
					s3_q[gi]  <= 1'b0;
					pin_q[gi] <= 1'b0;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi])
						pin_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate
	logic sec_s1_q, sec_s2_q, sec_s3_q, sec_n_q;
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			sec_s1_q <= 1'b1;
			sec_s2_q <= 1'b1;
			sec_s3_q <= 1'b1;
			sec_n_q  <= 1'b1;
		end else begin
			sec_s1_q <= security_n_i;
			sec_s2_q <= sec_s1_q;
			sec_s3_q <= sec_s2_q;
			if (sec_s2_q == sec_s3_q)
				sec_n_q <= sec_s3_q;
		end
	end
	wire key_on   = pin_q[0];
	wire start_rq = pin_q[1];
	wire helm2_ok = pin_q[2];
	wire tach_lvl = pin_q[3];
	wire [4:0] eng_al = pin_q[8:4];
	wire low_volt = pin_q[9];
	wire disp_ok  = pin_q[10];
	wire sec_act  = !sec_n_q;

	// free-running one-second tick
	logic [31:0] tick_cnt_q;
	wire sec_tick = (tick_cnt_q == SEC_CYCLES - 1);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) tick_cnt_q <= 32'h0000_0000;
		else tick_cnt_q <= sec_tick ? 32'h0000_0000 : tick_cnt_q + 32'd1;
	end

	// power sequencing
	eimon_pwr_t pwr_q, pwr_d;
	logic [7:0] sec_cnt_q;
	always_comb begin
		pwr_d = pwr_q;
		case (pwr_q)
			EIMON_OFF:  if (key_on) pwr_d = EIMON_RUN;
			EIMON_RUN:  if (!key_on) pwr_d = EIMON_STOP;
			EIMON_STOP: if (sec_tick && sec_cnt_q == 8'(STOP_S - 1))
				pwr_d = EIMON_OFF;
			default:    pwr_d = EIMON_OFF;
		endcase
	end
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pwr_q     <= EIMON_OFF;
			sec_cnt_q <= 8'h00;
		end else begin
			pwr_q <= pwr_d;
			if (pwr_d != pwr_q) sec_cnt_q <= 8'h00;
			else if (sec_tick && sec_cnt_q != 8'hFF)
				sec_cnt_q <= sec_cnt_q + 8'd1;
		end
	end
	wire run = (pwr_q == EIMON_RUN);
	// check-engine alarm window, seconds 3..4 after key on
	wire chk_al = run && sec_cnt_q >= 8'(CHK_LO) && sec_cnt_q < 8'(CHK_HI);

	// configuration registers (retained in flops across low power)
	logic [31:0] cfg_q;
	logic [15:0] cal_q;   // alternator ppr x100
	wire [2:0] eng_type = cfg_q[`EIMON_CFG_ENG_LSB +: 3];
	wire       tach_alt = cfg_q[`EIMON_CFG_TACH_BIT];
	wire       dual     = cfg_q[`EIMON_CFG_DUAL_BIT];

	// tach: count pulses per second; rpm = pulses*60*100/ppr100
	logic [15:0] ppr100;
	always_comb begin
		case (eng_type)
			3'd0:    ppr100 = 16'd11700;
			3'd1:    ppr100 = 16'd12900;
			3'd2:    ppr100 = 16'd12700;
			3'd3:    ppr100 = 16'd11600;
			default: ppr100 = 16'd9700;
		endcase
		if (tach_alt) ppr100 = cal_q;
	end
	logic        tach_d1_q;
	logic [15:0] pulse_cnt_q, rpm_q;
	wire tach_edge = tach_lvl && !tach_d1_q;
	wire [31:0] rpm_calc = (32'(pulse_cnt_q) * 32'd6000) /
		((ppr100 == 16'h0000) ? 32'd1 : 32'(ppr100));
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			tach_d1_q   <= 1'b0;
			pulse_cnt_q <= 16'h0000;
			rpm_q       <= 16'h0000;
		end else begin
			tach_d1_q <= tach_lvl;
			if (sec_tick) begin
				rpm_q       <= run ? rpm_calc[15:0] : 16'h0000;
				pulse_cnt_q <= 16'(tach_edge);
			end else if (tach_edge && pulse_cnt_q != 16'hFFFF)
				pulse_cnt_q <= pulse_cnt_q + 16'd1;
		end
	end
	// nonzero rpm from this second's pulse count also counts as running while run
	wire eng_run = (rpm_q != 16'h0000) || (rpm_calc != 32'd0 && run);

	// maintenance timer in running seconds
	logic [31:0] msec_q;
	logic [15:0] due_h_q;
	logic        maint_al_q, m_clr;
	wire [31:0] due_s = 32'(due_h_q) * 32'(`EIMON_SEC_PER_H);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			msec_q     <= 32'h0000_0000;
			due_h_q    <= 16'(M_FIRST);
			maint_al_q <= 1'b0;
		end else if (m_clr) begin
			msec_q     <= 32'h0000_0000;
			due_h_q    <= 16'(M_FIRST);
			maint_al_q <= 1'b0;
		end else if (disp_ok && eng_run && sec_tick) begin
			msec_q <= msec_q + 32'd1;
			if (msec_q + 32'd1 >= due_s) begin
				maint_al_q <= 1'b1;
				due_h_q    <= due_h_q + 16'(M_NEXT);
			end
		end
	end

	// alarms
	wire sec_al = run && sec_act && start_rq;
	logic [9:0] al_raw;
	assign al_raw = {sec_al, chk_al, sec_al, maint_al_q && disp_ok,
		low_volt, eng_al};
	localparam logic [9:0] ALWAYS_ON = (10'h001 << `EIMON_AL_CLVL) |
		(10'h001 << `EIMON_AL_CTMP) | (10'h001 << `EIMON_AL_WIF) |
		(10'h001 << `EIMON_AL_VOLT) | (10'h001 << `EIMON_AL_CHECK) |
		(10'h001 << `EIMON_AL_SEC) | (10'h001 << `EIMON_AL_WARN1);
	// check and security alarms are shown with engine stopped by design
	wire [9:0] al_now = run ? (eng_run ? al_raw : (al_raw & ALWAYS_ON))
		: 10'h000;

	// broadcast period
	logic [7:0] bc_cnt_q;
	wire bc_fire = run && sec_tick && bc_cnt_q == 8'(BCAST_SEC - 1);
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) bc_cnt_q <= 8'h00;
		else if (!run) bc_cnt_q <= 8'h00;
		else if (sec_tick) bc_cnt_q <= bc_fire ? 8'h00 : bc_cnt_q + 8'd1;
	end

	// rudder: 10..180 ohm -> -40..+40, 170 ohm span over 80 degrees
	wire [7:0] ohm_c = (sens2_ohm_i < 8'd10) ? 8'd10 :
		(sens2_ohm_i > 8'd180) ? 8'd180 : sens2_ohm_i;
	wire [15:0] rud_num = 16'(ohm_c - 8'd10) * 16'd80;
	wire [7:0] rudder = 8'(rud_num / 16'd170) - 8'd40;

	// outputs
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			mod_pwr_o  <= 1'b0;
			net_pwr_o  <= 1'b0;
			eng_stop_o <= 1'b0;
			start_en_o <= 1'b0;
			buzzer_o   <= 1'b0;
			bcast_o    <= 1'b0;
			alarm_o    <= 10'h000;
		end else begin
			mod_pwr_o  <= pwr_q != EIMON_OFF;
			net_pwr_o  <= run;
			eng_stop_o <= (pwr_q == EIMON_STOP) || sec_al;
			start_en_o <= run && (!dual || helm2_ok);
			buzzer_o   <= chk_al;
			bcast_o    <= bc_fire;
			if (bc_fire) alarm_o <= al_now;
		end
	end

	// wishbone classic slave, ack one cycle after strobe
	wire        req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	wire [4:0]  adr = wb_adr_i[4:0];
	wire        hit = (wb_adr_i[31:5] == 27'h0) && (adr[1:0] == 2'b00);
	wire        wr  = req && hit && wb_we_i;
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] cfg_w = (cfg_q & ~wmask) | (wb_dat_i & wmask);
	wire [15:0] cal_w = (cal_q & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
	assign m_clr = wr && adr == `EIMON_REG_CTRL && wb_sel_i[0] && wb_dat_i[0];
	logic [31:0] rd;
	always_comb begin
		case (adr)
			`EIMON_REG_CFG:    rd = cfg_q;
			`EIMON_REG_STATUS: rd = {24'h0, sec_act, eng_run, disp_ok, helm2_ok,
				key_on, eng_stop_o, net_pwr_o, mod_pwr_o};
			`EIMON_REG_ALARM:  rd = {22'h0, al_now};
			`EIMON_REG_RPM:    rd = {16'h0, rpm_q};
			`EIMON_REG_MAINT:  rd = msec_q;
			`EIMON_REG_CAL:    rd = {16'h0, cal_q};
			`EIMON_REG_SENS:   rd = {24'h0, rudder};
			default:           rd = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge core_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q    <= `EIMON_CFG_RESET;
			cal_q    <= `EIMON_CAL_RESET;
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req && hit;
			wb_err_o <= req && !hit;
			if (req && hit && !wb_we_i) wb_dat_o <= rd;
			if (wr && adr == `EIMON_REG_CFG) cfg_q <= cfg_w;
			if (wr && adr == `EIMON_REG_CAL) cal_q <= cal_w;
		end
	end

	a_stop_in_off: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		pwr_q == EIMON_STOP |=> eng_stop_o) else $error("stop missing");
	a_net_off_key: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		pwr_q != EIMON_RUN |=> !net_pwr_o) else $error("net pwr on");
	a_buzz_window: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		buzzer_o |-> $past(run) && $past(sec_cnt_q) >= 8'(CHK_LO))
		else $error("buzzer early");
	a_sec_fuel: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		run && sec_act && start_rq |=> eng_stop_o)
		else $error("no fuel cut");
	a_helm_inhib: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		dual && !helm2_ok |=> !start_en_o) else $error("helm start");
	a_supp_stop: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		!eng_run |-> al_now[`EIMON_AL_OIL] == 1'b0)
		else $error("oil alarm leak");
	a_maint_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		m_clr |=> msec_q == 32'h0 && !maint_al_q)
		else $error("maint clear");
	a_warn_sec: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		al_now[`EIMON_AL_SEC] == al_now[`EIMON_AL_WARN1])
		else $error("warning mismatch");
	a_off_end: assert property (@(posedge core_clk_i) disable iff (!rst_n)
		pwr_q == EIMON_STOP && sec_tick && sec_cnt_q == 8'(STOP_S - 1)
		|=> pwr_q == EIMON_OFF) else $error("no power down");
	a_net_on_run: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		run |=> net_pwr_o) else $error("net pwr off");
	a_mod_pwr_off: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		pwr_q == EIMON_OFF |=> !mod_pwr_o) else $error("module still on");
	a_off_no_stop: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		pwr_q == EIMON_OFF |=> !eng_stop_o) else $error("stop in low power");
	a_crank_free: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		run && !dual |=> start_en_o) else $error("cranking blocked");
	a_volt_kept: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		run |-> al_now[`EIMON_AL_VOLT] == low_volt) else $error("volt alarm");
	a_all_quiet: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		!run |-> al_now == 10'h000) else $error("alarm while off");
	a_maint_hold: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		!disp_ok && !m_clr |=> msec_q == $past(msec_q))
		else $error("maint ran without display");
	a_bc_pulse: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		bcast_o |=> !bcast_o) else $error("broadcast stuck");
	a_chk_end: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		buzzer_o |-> $past(sec_cnt_q) < 8'(CHK_HI)) else $error("buzzer late");
	a_ack_one: assert property (
		@(posedge core_clk_i) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule : eimon_top
`default_nettype wire

// ---- sim/eimon_engine_model.sv ----
// engine side model: magnetic pickup pulse train while the engine turns
`default_nettype none
module eimon_engine_model (
	input  wire logic       clk_i, // bench clock
	input  wire logic       run_i, // engine turning
	input  wire logic [3:0] per_i, // cycles between pickup pulses
	output logic            tach_o // pickup pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q = 4'h0;
	logic       tach_q = 1'b0;
	assign tach_o = tach_q;
	// a stopped engine leaves the pickup low, so no stray edges reach rpm
	always_ff @(posedge clk_i) begin
		cnt_q <= (!run_i || cnt_q >= per_i - 4'h1) ? 4'h0 : cnt_q + 4'h1;
		// half-period high: single-cycle pulses never pass the pin filter
		tach_q <= run_i && cnt_q < (per_i >> 1);
	end
endmodule : eimon_engine_model
`default_nettype wire

// ---- sim/eimon_top_tb.sv ----
// self-checking bench for the engine interface monitor top
`include "eimon_params.svh"
`default_nettype none
module eimon_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 20;
	logic        clk, rst_n, key, start, sec_n, helm2, run, lv, disp;
	logic        cyc, stb, we, ack, err, e, mpwr, npwr, stop, sten, buz, bc;
	logic        tach;
	logic [3:0]  sel;
	logic [4:0]  eng;
	logic [7:0]  ohm;
	logic [9:0]  al;
	logic [31:0] adr, wdat, dat_o, rd, m0, m1;
	logic [7:0]  rohm [3] = '{8'd10, 8'd95, 8'd180};
	logic [7:0]  rdeg [3] = '{8'hD8, 8'h00, 8'h28};
	int          failures = 0;
	int          total_checks = 0;
	int          i, n;

	eimon_top #(.SEC_CYCLES(SC), .BCAST_SEC(1)) dut (
		.core_clk_i(clk), .rst_n_i(rst_n), .key_on_i(key),
		.start_cmd_i(start), .security_n_i(sec_n), .helm2_ok_i(helm2),
		.tach_pulse_i(tach), .eng_alarm_i(eng), .low_volt_i(lv),
		.display_i(disp), .sens2_ohm_i(ohm), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
		.mod_pwr_o(mpwr), .net_pwr_o(npwr), .eng_stop_o(stop),
		.start_en_o(sten), .buzzer_o(buz), .bcast_o(bc), .alarm_o(al)
	);
	eimon_engine_model eng_model (.clk_i(clk), .run_i(run),
		.per_i(4'h4), .tach_o(tach));

	task automatic print_verdict();
		if (failures == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic hang(input string nm);
		chk(nm, 32'h0, 32'h1);
		print_verdict();
	endtask : hang

	// one classic cycle; rd and e hold what came back at the ack edge
	task automatic bus(input logic w, input logic [31:0] a, d,
		input logic [3:0] s);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
		n = 0;
		do begin
			@(posedge clk);
			if (++n > 20) hang("bus_answer");
		end while (ack !== 1'b1 && err !== 1'b1);
		rd = dat_o;
		e = err;
		{cyc, stb} <= 2'b00;
	endtask : bus

	task automatic wait_bc();
		n = 0;
		do begin
			@(posedge clk);
			if (++n > 100) hang("bcast_wait");
		end while (bc !== 1'b1);
	endtask : wait_bc

	function automatic logic [9:0] exp_al(input logic [4:0] a,
		input logic v, r, s);
		return {s, 1'b0, s, 1'b0, v, a & (r ? 5'h1F : 5'h0E)};
	endfunction : exp_al

	function automatic logic [31:0] exp_rpm(input int p, q);
		return 32'(p * 6000 / q);
	endfunction : exp_rpm

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		{rst_n, key, start, helm2, run, lv, disp, cyc, stb, we} = '0;
		{adr, wdat, sel, eng} = '0;
		sec_n = 1'b1;
		ohm = 8'd10;
		n = $urandom(83204);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		bus(0, 32'(`EIMON_REG_CFG), 32'h0, 4'hF);
		chk("cfg_reset", rd, `EIMON_CFG_RESET);
		bus(0, 32'(`EIMON_REG_CAL), 32'h0, 4'hF);
		chk("cal_reset", rd, 32'(`EIMON_CAL_RESET));
		bus(1, 32'(`EIMON_REG_CAL), 32'h0000_0400, 4'h3);
		bus(0, 32'(`EIMON_REG_CAL), 32'h0, 4'hF);
		chk("cal_write", rd, 32'h0000_0400);
		bus(0, 32'h0000_0020, 32'h0, 4'hF);
		chk("unmapped_err", 32'(e), 32'h1);
		key <= 1'b1;
		for (i = 0; buz !== 1'b1; i++) begin
			if (i > 6 * SC) hang("buzzer_on");
			@(posedge clk);
		end
		chk("power_up", 32'({mpwr, npwr}), 32'h3);
		chk("check_delay", 32'(i >= 2 * SC && i <= 3 * SC + 8), 32'h1);
		for (i = 0; buz === 1'b1; i++) begin
			if (i > 4 * SC) hang("buzzer_off");
			@(posedge clk);
		end
		chk("check_len", i, 2 * SC);
		wait_bc();
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (bc !== 1'b1 && i < 100);
		chk("bcast_gap", i, SC);
		for (int r = 0; r < 2; r++) begin
			run <= r[0];
			repeat (3) wait_bc();
			for (i = 0; i < 3; i++) begin
				eng <= 5'($urandom);
				lv <= 1'($urandom);
				repeat (2) wait_bc();
				chk("alarms", 32'(al), 32'(exp_al(eng, lv, r[0], 1'b0)));
			end
		end
		bus(0, 32'(`EIMON_REG_RPM), 32'h0, 4'hF);
		chk("rpm", rd, exp_rpm(SC / 4, 11700));
		bus(0, 32'(`EIMON_REG_STATUS), 32'h0, 4'hF);
		chk("eng_running", 32'(rd[6]), 32'h1);
		bus(0, 32'(`EIMON_REG_ALARM), 32'h0, 4'hF);
		chk("alarm_reg", rd, 32'(exp_al(eng, lv, 1'b1, 1'b0)));
		disp <= 1'b1;
		repeat (2) wait_bc();
		bus(0, 32'(`EIMON_REG_MAINT), 32'h0, 4'hF);
		m0 = rd;
		repeat (4) wait_bc();
		bus(0, 32'(`EIMON_REG_MAINT), 32'h0, 4'hF);
		chk("maint_runs", 32'(rd - m0 >= 3 && rd - m0 <= 5), 32'h1);
		disp <= 1'b0;
		repeat (8) @(posedge clk);
		bus(0, 32'(`EIMON_REG_MAINT), 32'h0, 4'hF);
		m0 = rd;
		repeat (3) wait_bc();
		bus(0, 32'(`EIMON_REG_MAINT), 32'h0, 4'hF);
		chk("maint_idle", rd, m0);
		bus(1, 32'(`EIMON_REG_CTRL), 32'h1, 4'hF);
		bus(0, 32'(`EIMON_REG_MAINT), 32'h0, 4'hF);
		chk("maint_clear", rd, 32'h0);
		for (i = 0; i < 3; i++) begin
			ohm <= rohm[i];
			repeat (6) @(posedge clk);
			bus(0, 32'(`EIMON_REG_SENS), 32'h0, 4'hF);
			chk("rudder", 32'(rd[7:0]), 32'(rdeg[i]));
		end
		run <= 1'b0;
		for (i = 0; i < 4; i++) begin
			m0 = ($urandom & 32'h01FF_FFF8) | ($urandom % 5);
			bus(1, 32'(`EIMON_REG_CFG), m0, 4'hF);
			bus(0, 32'(`EIMON_REG_CFG), 32'h0, 4'hF);
			chk("cfg_rw", rd, m0);
		end
		bus(1, 32'(`EIMON_REG_CFG), 32'hFFFF_ABFF, 4'h2);
		m0 = (m0 & 32'hFFFF_00FF) | 32'h0000_AB00;
		bus(0, 32'(`EIMON_REG_CFG), 32'h0, 4'hF);
		chk("cfg_sensor1", rd, m0);
		bus(1, 32'(`EIMON_REG_CFG), m0 | 32'h0200_0000, 4'hF);
		repeat (8) @(posedge clk);
		chk("helm2_missing", 32'(sten), 32'h0);
		helm2 <= 1'b1;
		repeat (8) @(posedge clk);
		chk("helm2_present", 32'(sten), 32'h1);
		bus(1, 32'(`EIMON_REG_CFG), m0, 4'hF);
		start <= 1'b1;
		repeat (8) @(posedge clk);
		chk("start_no_sec", 32'(stop), 32'h0);
		sec_n <= 1'b0;
		for (i = 0; stop !== 1'b1; i++) begin
			if (i > 20) hang("fuel_cut");
			@(posedge clk);
		end
		chk("crank_allowed", 32'(sten), 32'h1);
		repeat (2) wait_bc();
		chk("sec_alarms", 32'({al[9], al[7]}), 32'h3);
		{sec_n, start} <= 2'b10;
		repeat (8) @(posedge clk);
		key <= 1'b0;
		for (i = 0; npwr !== 1'b0; i++) begin
			if (i > 20) hang("net_off");
			@(posedge clk);
		end
		chk("stop_on", 32'(stop), 32'h1);
		for (i = 0; stop === 1'b1; i++) begin
			if (i > 12 * SC) hang("stop_off");
			@(posedge clk);
		end
		chk("stop_len", 32'(i >= 9 * SC && i <= 10 * SC + 4), 32'h1);
		repeat (3) @(posedge clk);
		chk("low_power", 32'({mpwr, npwr}), 32'h0);
		key <= 1'b1;
		repeat (10) @(posedge clk);
		bus(0, 32'(`EIMON_REG_CFG), 32'h0, 4'hF);
		chk("cfg_kept", rd, m0);
		print_verdict();
	end
endmodule : eimon_top_tb
`default_nettype wire
